// File: common/jtb_pkg.sv
// Types shared by the boundary-scan test port modules.
// Assumes jtb_regs.svh supplies the widths.
`include "jtb_regs.svh"

package jtb_pkg;

  typedef enum logic [3:0] {
    TAP_TLR   = 4'b1111,
    TAP_RTI   = 4'b1100,
    TAP_SELDR = 4'b0111,
    TAP_CAPDR = 4'b0110,
    TAP_SHDR  = 4'b0010,
    TAP_EX1DR = 4'b0001,
    TAP_PDR   = 4'b0011,
    TAP_EX2DR = 4'b0000,
    TAP_UPDR  = 4'b0101,
    TAP_SELIR = 4'b0100,
    TAP_CAPIR = 4'b1110,
    TAP_SHIR  = 4'b1010,
    TAP_EX1IR = 4'b1001,
    TAP_PIR   = 4'b1011,
    TAP_EX2IR = 4'b1000,
    TAP_UPIR  = 4'b1101
  } jtb_tap_e;

  typedef logic [`JTB_IR_W-1:0] jtb_ir_t;

endpackage : jtb_pkg

// File: common/jtb_regs.svh
// Named constants for the boundary-scan test port: instruction codes,
// chain length and the positions of the four pin-group control cells.
// Assumes it is included by bare name from the design modules.
`ifndef JTB_REGS_SVH
`define JTB_REGS_SVH

`define JTB_IR_W         4
`define JTB_IR_CAPTURE   4'h1
`define JTB_OP_EXTEST    4'h0
`define JTB_OP_SAMPLE    4'h1
`define JTB_OP_IDCODE    4'h2
`define JTB_OP_BYPASS    4'hf

`define JTB_CHAIN_LEN    150
`define JTB_ID_W         32
`define JTB_GRP_N        4

// Group order in pin_oe_grp: data, address, tristate, always driven
`define JTB_GRP_DATA     0
`define JTB_GRP_ADDR     1
`define JTB_GRP_TRI      2
`define JTB_GRP_ALWAYS   3

// Control cell positions in the chain, cell 0 being next to TDO
`define JTB_CELL_DATA    146
`define JTB_CELL_ADDR    147
`define JTB_CELL_TRI     148
`define JTB_CELL_ALWAYS  149

`endif

// File: src/jtb_bsc_chain.sv
// Boundary scan chain: serial shift stages and a latched parallel side.
// Assumes strobes are one-cycle pulses aligned to sampled TCK edges.
`timescale 1ns/1ps
`include "jtb_regs.svh"

module jtb_bsc_chain #(
  parameter int N = `JTB_CHAIN_LEN
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic         tck_rise,
  input  wire logic         tck_fall,
  input  wire logic         sel,
  input  wire logic         in_capture,
  input  wire logic         in_shift,
  input  wire logic         in_update,
  input  wire logic         tdi,
  input  wire logic [N-1:0] cap_in,
  output logic              ser_out,
  output logic [N-1:0]      upd_q
);

  logic [N-1:0] shift_reg;
  logic [N-1:0] upd_reg;

  // Stage 0 is next to TDO; new bits enter at the far end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= '0;
    end else if (ce && sel && tck_rise) begin
      if (in_capture) begin
        shift_reg <= cap_in;
      end else if (in_shift) begin
        shift_reg <= {tdi, shift_reg[N-1:1]};
      end
    end
  end

  // Parallel side moves only in Update-DR, so pins hold during a scan
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      upd_reg <= '0;
    end else if (ce && sel && tck_fall && in_update) begin
      upd_reg <= shift_reg;
    end
  end

  assign ser_out = shift_reg[0];
  assign upd_q   = upd_reg;

endmodule : jtb_bsc_chain

// File: src/jtb_tap_fsm.sv
// Test access port state machine, stepped by sampled TCK rising edges.
// Assumes tck_rise is a one-cycle pulse and tms is already synchronised.
`timescale 1ns/1ps

module jtb_tap_fsm
  import jtb_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     arst_n,
  input  wire logic     ce,
  input  wire logic     tck_rise,
  input  wire logic     tms,
  input  wire logic     test_rst,
  output jtb_tap_e      state
);

  jtb_tap_e state_reg;
  jtb_tap_e state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TAP_TLR:   state_next = tms ? TAP_TLR   : TAP_RTI;
      TAP_RTI:   state_next = tms ? TAP_SELDR : TAP_RTI;
      TAP_SELDR: state_next = tms ? TAP_SELIR : TAP_CAPDR;
      TAP_CAPDR: state_next = tms ? TAP_EX1DR : TAP_SHDR;
      TAP_SHDR:  state_next = tms ? TAP_EX1DR : TAP_SHDR;
      TAP_EX1DR: state_next = tms ? TAP_UPDR  : TAP_PDR;
      TAP_PDR:   state_next = tms ? TAP_EX2DR : TAP_PDR;
      TAP_EX2DR: state_next = tms ? TAP_UPDR  : TAP_SHDR;
      TAP_UPDR:  state_next = tms ? TAP_SELDR : TAP_RTI;
      TAP_SELIR: state_next = tms ? TAP_TLR   : TAP_CAPIR;
      TAP_CAPIR: state_next = tms ? TAP_EX1IR : TAP_SHIR;
      TAP_SHIR:  state_next = tms ? TAP_EX1IR : TAP_SHIR;
      TAP_EX1IR: state_next = tms ? TAP_UPIR  : TAP_PIR;
      TAP_PIR:   state_next = tms ? TAP_EX2IR : TAP_PIR;
      TAP_EX2IR: state_next = tms ? TAP_UPIR  : TAP_SHIR;
      TAP_UPIR:  state_next = tms ? TAP_SELDR : TAP_RTI;
      default:   state_next = TAP_TLR;
    endcase
  end

  // Five TMS-high edges reach reset from any state by the table above
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= TAP_TLR;
    end else if (ce) begin
      if (test_rst) begin
        state_reg <= TAP_TLR;
      end else if (tck_rise) begin
        state_reg <= state_next;
      end
    end
  end

  assign state = state_reg;

endmodule : jtb_tap_fsm

// File: src/jtb_top.sv
// Boundary-scan test port: TAP controller, instruction path, identity,
// bypass and a 150-cell boundary chain steering the pin groups.
// Assumes TCK, TMS, TDI, test reset and pin levels arrive asynchronously
// and are oversampled by clk_sys, which must run well above TCK.
//
// What this block does
// - Shift-IR shifts instruction register toward TDO
// - Shift-IR: TMS high exits, low stays
// - Exit1-IR: high updates, low pauses
// - Pause-IR holds while low, high to Exit2
// - Exit2-IR: high updates, low resumes shifting
// - Exit/pause hold instruction, data and shifter
// - Update-IR falling edge loads current instruction
// - Update-IR leaves selected data registers unchanged
// - Chain has 150 cells, TDI has none
// - Four control cells enable the pin groups
// - EXTEST: control cell one floats its group
// - Pins follow the core, or in EXTEST cells updated only at Update-DR
// - EXTEST: capture pins, drive outputs from cells
// - SAMPLE: capture pins and core, normal pins
// - Five TMS-high edges or test reset initialise
// - Test reset acts without TCK edges
// - Capture-IR loads pattern 0001
// - Test-Logic-Reset selects the identity instruction
`timescale 1ns/1ps
`include "jtb_regs.svh"

module jtb_top
  import jtb_pkg::*;
#(
  parameter int                 N         = `JTB_CHAIN_LEN,
  // Arbitrary identity value; bit 0 is one as the identity marker
  parameter logic [`JTB_ID_W-1:0] ID_VALUE = 32'h0000_0001,
  // Set bits mark cells that drive a pin from the core side
  parameter logic [N-1:0]       OUT_CELLS = {N{1'b1}}
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  input  wire logic                  trst_n,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic [N-1:0]          pin_in,
  input  wire logic [N-1:0]          core_out,
  input  wire logic [`JTB_GRP_N-1:0] core_oe_grp,
  output logic [N-1:0]               pin_out,
  output logic [`JTB_GRP_N-1:0]      pin_oe_grp,
  output logic [N-1:0]               core_in,
  output jtb_tap_e                   tap_state,
  output jtb_ir_t                    cur_instr
);

  function automatic logic uses_chain(input jtb_ir_t op);
    uses_chain = (op == `JTB_OP_EXTEST) || (op == `JTB_OP_SAMPLE);
  endfunction : uses_chain

  function automatic logic is_op(input jtb_ir_t op, input jtb_ir_t code);
    is_op = (op == code);
  endfunction : is_op

  // Synchronisers; stage one feeds only stage two
  logic [3:0]   ctl_s1_reg;
  logic [3:0]   ctl_s2_reg;
  logic         tck_d_reg;
  logic [N-1:0] pin_s1_reg;
  logic [N-1:0] pin_s2_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl_s1_reg <= 4'h8;
      ctl_s2_reg <= 4'h8;
    end else if (ce) begin
      ctl_s1_reg <= {trst_n, tdi, tms, tck};
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else if (ce) begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s_n;

  assign tck_s    = ctl_s2_reg[0];
  assign tms_s    = ctl_s2_reg[1];
  assign tdi_s    = ctl_s2_reg[2];
  assign trst_s_n = ctl_s2_reg[3];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tck_d_reg <= 1'b0;
    end else if (ce) begin
      tck_d_reg <= tck_s;
    end
  end

  logic tck_rise;
  logic tck_fall;

  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  jtb_tap_e state;

  jtb_tap_fsm u_fsm (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .ce       (ce),
    .tck_rise (tck_rise),
    .tms      (tms_s),
    .test_rst (~trst_s_n),
    .state    (state)
  );

  // Instruction path
  jtb_ir_t ir_shift_reg;
  jtb_ir_t instr_reg;

  // Exit and pause states fall through, so the shifter holds
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ir_shift_reg <= `JTB_IR_CAPTURE;
    end else if (ce && tck_rise) begin
      case (state)
        TAP_CAPIR: ir_shift_reg <= `JTB_IR_CAPTURE;
        TAP_SHIR:  ir_shift_reg <= {tdi_s, ir_shift_reg[`JTB_IR_W-1:1]};
        default:   ir_shift_reg <= ir_shift_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      instr_reg <= `JTB_OP_IDCODE;
    end else if (ce) begin
      if (state == TAP_TLR) begin
        instr_reg <= `JTB_OP_IDCODE;
      end else if (tck_fall && state == TAP_UPIR) begin
        instr_reg <= ir_shift_reg;
      end
    end
  end

  logic sel_chain;
  logic sel_id;
  logic op_extest;

  assign sel_chain = uses_chain(instr_reg);
  assign sel_id    = is_op(instr_reg, `JTB_OP_IDCODE);
  assign op_extest = is_op(instr_reg, `JTB_OP_EXTEST);

  // Data registers act only in Capture-DR, Shift-DR and Update-DR;
  // the IR states leave them untouched
  logic st_capdr;
  logic st_shdr;
  logic st_updr;

  assign st_capdr = (state == TAP_CAPDR);
  assign st_shdr  = (state == TAP_SHDR);
  assign st_updr  = (state == TAP_UPDR);

  // Identity register
  logic [`JTB_ID_W-1:0] id_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      id_reg <= '0;
    end else if (ce && tck_rise && sel_id) begin
      if (st_capdr) begin
        id_reg <= ID_VALUE;
      end else if (st_shdr) begin
        id_reg <= {tdi_s, id_reg[`JTB_ID_W-1:1]};
      end
    end
  end

  // One-stage bypass for every instruction without its own register
  logic byp_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      byp_reg <= 1'b0;
    end else if (ce && tck_rise && !sel_id && !sel_chain) begin
      if (st_capdr) begin
        byp_reg <= 1'b0;
      end else if (st_shdr) begin
        byp_reg <= tdi_s;
      end
    end
  end

  // Boundary chain capture values
  logic [N-1:0] chain_cap;
  logic [N-1:0] chain_upd;
  logic         chain_out;

  always_comb begin
    chain_cap = '0;
    for (int i = 0; i < N; i++) begin
      if (OUT_CELLS[i] && !op_extest) begin
        chain_cap[i] = core_out[i];
      end else begin
        chain_cap[i] = pin_s2_reg[i];
      end
    end
    // Control cells have no pin; they read back their latched value
    chain_cap[`JTB_CELL_DATA]   = chain_upd[`JTB_CELL_DATA];
    chain_cap[`JTB_CELL_ADDR]   = chain_upd[`JTB_CELL_ADDR];
    chain_cap[`JTB_CELL_TRI]    = chain_upd[`JTB_CELL_TRI];
    chain_cap[`JTB_CELL_ALWAYS] = chain_upd[`JTB_CELL_ALWAYS];
  end

  jtb_bsc_chain #(
    .N (N)
  ) u_chain (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .ce         (ce),
    .tck_rise   (tck_rise),
    .tck_fall   (tck_fall),
    .sel        (sel_chain),
    .in_capture (st_capdr),
    .in_shift   (st_shdr),
    .in_update  (st_updr),
    .tdi        (tdi_s),
    .cap_in     (chain_cap),
    .ser_out    (chain_out),
    .upd_q      (chain_upd)
  );

  // Pin drive; the core never sees captured cell values
  logic [N-1:0]          pin_out_reg;
  logic [`JTB_GRP_N-1:0] pin_oe_reg;
  logic [N-1:0]          core_in_reg;
  logic [`JTB_GRP_N-1:0] ctl_cells;

  assign ctl_cells = {chain_upd[`JTB_CELL_ALWAYS], chain_upd[`JTB_CELL_TRI],
                      chain_upd[`JTB_CELL_ADDR], chain_upd[`JTB_CELL_DATA]};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else if (ce) begin
      if (op_extest) begin
        pin_out_reg <= chain_upd & OUT_CELLS;
        pin_oe_reg  <= ~ctl_cells;
      end else begin
        pin_out_reg <= core_out;
        pin_oe_reg  <= core_oe_grp;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      core_in_reg <= '0;
    end else if (ce) begin
      core_in_reg <= pin_s2_reg;
    end
  end

  // Serial output changes on the falling edge so the tester can
  // sample it on the next rising edge
  logic tdo_reg;
  logic tdo_oe_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (ce) begin
      if (state == TAP_TLR) begin
        tdo_reg    <= 1'b0;
        tdo_oe_reg <= 1'b0;
      end else if (tck_fall) begin
        tdo_oe_reg <= (state == TAP_SHIR) || st_shdr;
        if (state == TAP_SHIR) begin
          tdo_reg <= ir_shift_reg[0];
        end else if (st_shdr) begin
          tdo_reg <= sel_chain ? chain_out :
                     (sel_id ? id_reg[0] : byp_reg);
        end
      end
    end
  end

  assign tdo        = tdo_reg;
  assign tdo_oe     = tdo_oe_reg;
  assign pin_out    = pin_out_reg;
  assign pin_oe_grp = pin_oe_reg;
  assign core_in    = core_in_reg;
  assign tap_state  = state;
  assign cur_instr  = instr_reg;

endmodule : jtb_top

// File: tb/jtb_props.sv
// Concurrent checks on the test port outputs, bound into jtb_top.
// Assumes one clock domain, clk_sys, with arst_n as its reset.
`timescale 1ns/1ps
`include "jtb_regs.svh"

module jtb_props
  import jtb_pkg::*;
#(
  parameter int N = `JTB_CHAIN_LEN
) (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic                  trst_n,
  input wire logic                  tdo_oe,
  input wire logic [N-1:0]          pin_out,
  input wire logic [`JTB_GRP_N-1:0] pin_oe_grp,
  input jtb_tap_e                   tap_state,
  input jtb_ir_t                    cur_instr
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Test reset may pull any state to TLR, so TLR is always allowed
  chk_shir_exit: assert property (
    $past(tap_state) == TAP_SHIR && tap_state != TAP_SHIR
    |-> tap_state inside {TAP_EX1IR, TAP_TLR})
    else $error("bad exit from shift-ir");
  chk_ex1ir_next: assert property (
    $past(tap_state) == TAP_EX1IR && tap_state != TAP_EX1IR
    |-> tap_state inside {TAP_UPIR, TAP_PIR, TAP_TLR})
    else $error("bad exit from exit1-ir");
  chk_pause_next: assert property (
    $past(tap_state) == TAP_PIR && tap_state != TAP_PIR
    |-> tap_state inside {TAP_EX2IR, TAP_TLR})
    else $error("bad exit from pause-ir");
  chk_ex2ir_next: assert property (
    $past(tap_state) == TAP_EX2IR && tap_state != TAP_EX2IR
    |-> tap_state inside {TAP_UPIR, TAP_SHIR, TAP_TLR})
    else $error("bad exit from exit2-ir");
  chk_instr_hold: assert property (
    tap_state inside {TAP_SHIR, TAP_EX1IR, TAP_PIR, TAP_EX2IR}
    |=> $stable(cur_instr) || tap_state == TAP_TLR)
    else $error("instruction moved during ir scan");
  chk_instr_update: assert property (
    $changed(cur_instr) |-> tap_state inside {TAP_UPIR, TAP_TLR})
    else $error("instruction changed outside update");
  chk_tlr_idcode: assert property (
    tap_state == TAP_TLR && $past(tap_state) == TAP_TLR
    |-> cur_instr == `JTB_OP_IDCODE)
    else $error("reset state without identity instruction");
  chk_tdo_enable: assert property (
    $rose(tdo_oe) |-> tap_state inside {TAP_SHIR, TAP_SHDR})
    else $error("tdo enabled outside shift");
  chk_pins_frozen: assert property (
    cur_instr == `JTB_OP_EXTEST && tap_state == TAP_SHDR
    && $past(tap_state) == TAP_SHDR
    |-> $stable(pin_out) && $stable(pin_oe_grp))
    else $error("pins moved during shift-dr");
  chk_upir_data: assert property (
    tap_state == TAP_UPIR && $past(tap_state) == TAP_UPIR
    && $past(cur_instr, 2) == `JTB_OP_EXTEST
    && cur_instr == `JTB_OP_EXTEST |-> $stable(pin_out))
    else $error("chain output moved in update-ir");
  chk_trst_async: assert property (
    !trst_n [*5] |-> tap_state == TAP_TLR
    && cur_instr == `JTB_OP_IDCODE)
    else $error("test reset not honoured");
endmodule : jtb_props

bind jtb_top jtb_props #(.N(N)) props_u (
  .clk_sys    (clk_sys),
  .arst_n     (arst_n),
  .trst_n     (trst_n),
  .tdo_oe     (tdo_oe),
  .pin_out    (pin_out),
  .pin_oe_grp (pin_oe_grp),
  .tap_state  (tap_state),
  .cur_instr  (cur_instr)
);

// File: tb/jtb_tester.sv
// Tester model: drives TCK, TMS, TDI and test reset, reads TDO.
// Assumes clk_sys is the bench clock; one TCK period is 8 of its cycles.
`timescale 1ns/1ps

module jtb_tester (
  input  wire logic clk_sys,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  logic last_q;

  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    trst_n = 1'b1;
    last_q = 1'b0;
  end

  // TCK stands still between calls; q is the bit this rise shifts out
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk_sys);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk_sys);
    tck <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    // A released TDO line must not read as the last driven bit
    q = tdo_oe ? tdo : ~last_q;
    last_q = q;
  endtask : step

  task automatic reset_drive(input logic v);
    @(posedge clk_sys);
    trst_n <= v;
  endtask : reset_drive
endmodule : jtb_tester

// File: tb/jtb_top_test.sv
// Self-checking bench: IR scans with pause, EXTEST and SAMPLE chain scans,
// TMS and test-reset initialisation. Assumes jtb_tester and jtb_props.
`timescale 1ns/1ps
`include "jtb_regs.svh"

module jtb_top_test;
  import jtb_pkg::*;
  localparam int           N        = `JTB_CHAIN_LEN;
  localparam logic [N-1:0] PIN_PAT  = {2'h2, {37{4'ha}}};
  localparam logic [145:0] CELL_PAT = {2'h1, {36{4'h5}}};
  // Identity value is arbitrary; bit 0 set as the identity marker
  localparam logic [`JTB_ID_W-1:0] ID_VAL = 32'h5a5a_0001;
  logic                  clk_sys     = 1'b0;
  logic                  arst_n      = 1'b0;
  logic                  ce          = 1'b1;
  logic [N-1:0]          pin_in      = PIN_PAT;
  logic [N-1:0]          core_out    = {2'h3, {37{4'h6}}};
  logic [`JTB_GRP_N-1:0] core_oe_grp = 4'h6;
  logic                  tck, tms, tdi, trst_n, tdo, tdo_oe, q;
  logic [N-1:0]          pin_out, core_in;
  logic [`JTB_GRP_N-1:0] pin_oe_grp;
  logic [N:0]            got;
  jtb_tap_e              tap_state, st;
  jtb_ir_t               cur_instr;
  int                    n_mismatch  = 0;
  int                    check_count = 0;

  always #20 clk_sys = ~clk_sys;

  jtb_tester tester_u (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

  jtb_top #(.N(N), .ID_VALUE(ID_VAL)) dut_u (.clk_sys(clk_sys),
    .arst_n(arst_n), .ce(ce),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
    .core_oe_grp(core_oe_grp), .pin_out(pin_out), .pin_oe_grp(pin_oe_grp),
    .core_in(core_in), .tap_state(tap_state), .cur_instr(cur_instr));

  task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check

  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // st is the state that governs this rise, read well after it settled
  task automatic clk_bit(input logic m, input logic d, output logic qo,
                         output jtb_tap_e so);
    fork
      tester_u.step(m, d, qo);
      begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        so = tap_state;
      end
    join
  endtask : clk_bit

  // From idle: capture, shift two bits, pause, resume, shift two, update
  task automatic ir_load(input jtb_ir_t code);
    logic     qi;
    jtb_tap_e si;
    jtb_ir_t  was;
    int       k;
    jtb_tap_e ex[14] = '{TAP_RTI, TAP_SELDR, TAP_SELIR, TAP_CAPIR,
      TAP_SHIR, TAP_SHIR, TAP_EX1IR, TAP_PIR, TAP_PIR, TAP_EX2IR,
      TAP_SHIR, TAP_SHIR, TAP_EX1IR, TAP_UPIR};
    logic [13:0] tms_seq = 14'h1923;
    was = cur_instr;
    k = 0;
    for (int i = 0; i < 14; i++) begin
      clk_bit(tms_seq[i], code[k[1:0]], qi, si);
      check(si, ex[i], "tap state");
      if (i < 13) check(cur_instr, was, "instr held");
      if (ex[i] == TAP_SHIR) begin
        check(qi, `JTB_IR_CAPTURE >> k, "ir out");
        k++;
      end
    end
    check(cur_instr, code, "instr loaded");
  endtask : ir_load

  task automatic dr_scan(input int n, input logic [N:0] din,
                         output logic [N:0] dout);
    logic     qd;
    jtb_tap_e sd;
    dout = '0;
    clk_bit(1'b1, 1'b0, qd, sd);
    clk_bit(1'b0, 1'b0, qd, sd);
    clk_bit(1'b0, 1'b0, qd, sd);
    for (int j = 0; j < n; j++) begin
      clk_bit(j == n - 1, din[j], qd, sd);
      dout[j] = qd;
    end
    clk_bit(1'b1, 1'b0, qd, sd);
    clk_bit(1'b0, 1'b0, qd, sd);
  endtask : dr_scan

  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check(cur_instr, `JTB_OP_IDCODE, "reset instr");
    check(tdo_oe, 1'b0, "tdo idle");
    check(pin_oe_grp, core_oe_grp, "normal enables");
    check(core_in, pin_in, "pins to core");
    clk_bit(1'b0, 1'b0, q, st);
    ir_load(`JTB_OP_EXTEST);
    // One extra bit proves the chain length by reappearing at TDO
    dr_scan(N + 1, {4'h5, CELL_PAT, 1'h1}, got);
    check(got[N-1:0], {4'h0, PIN_PAT[145:0]}, "captured pins");
    check(got[N], 1'h1, "chain length");
    check(pin_out, {4'h5, CELL_PAT}, "driven cells");
    check(pin_oe_grp, 4'ha, "group floats");
    check(tdo_oe, 1'b0, "tdo released");
    ir_load(`JTB_OP_SAMPLE);
    check(pin_out, core_out, "normal pins");
    check(pin_oe_grp, core_oe_grp, "normal enables back");
    dr_scan(N, '0, got);
    check(got[145:0], core_out[145:0], "sampled core");
    // Park in Shift-DR, one of the states five edges from reset, before TMS reset
    clk_bit(1'b1, 1'b0, q, st);
    clk_bit(1'b0, 1'b0, q, st);
    clk_bit(1'b0, 1'b0, q, st);
    for (int i = 0; i < 6; i++) clk_bit(1'b1, 1'b0, q, st);
    check(st, TAP_TLR, "five high edges");
    check(cur_instr, `JTB_OP_IDCODE, "instr after tms");
    clk_bit(1'b0, 1'b0, q, st);
    dr_scan(`JTB_ID_W, '0, got);
    check(got[`JTB_ID_W-1:0], ID_VAL, "identity");
    ir_load(`JTB_OP_EXTEST);
    tester_u.reset_drive(1'b0);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check(tap_state, TAP_TLR, "test reset state");
    check(cur_instr, `JTB_OP_IDCODE, "test reset instr");
    tester_u.reset_drive(1'b1);
    give_verdict();
  end
endmodule : jtb_top_test
